// file: rtl/fpp_pkg.sv
package fpp_pkg;
   // Register byte addresses on the APB
   localparam logic [7:0] FPP_CTRL1_ADDR = 8'h00;
   localparam logic [7:0] FPP_CTRL2_ADDR = 8'h04;
   localparam logic [7:0] FPP_EBS_ADDR = 8'h08;
   localparam logic [7:0] FPP_STATUS_ADDR = 8'h0C;
   // Field positions, control one
   localparam int FPP_C1_PROG = 0;
   localparam int FPP_C1_ERASE = 1;
   localparam int FPP_C1_PV = 2;
   localparam int FPP_C1_EV = 3;
   localparam int FPP_C1_WEG = 6;
   // Field positions, control two
   localparam int FPP_C2_PSU = 0;
   localparam int FPP_C2_ESU = 1;
   localparam int FPP_C2_ERR = 7;
   // Status register fields
   localparam int FPP_ST_PMODE = 0;
   localparam int FPP_ST_EMODE = 1;
   localparam int FPP_ST_PVMODE = 2;
   localparam int FPP_ST_EVMODE = 3;
   localparam int FPP_ST_ERRPROT = 4;
   localparam int FPP_ST_IRQOFF = 5;
   // Reset values and write masks
   localparam logic [7:0] FPP_CTRL1_RST = 8'h00;
   localparam logic [7:0] FPP_CTRL2_RST = 8'h00;
   localparam logic [7:0] FPP_EBS_RST = 8'h00;
   localparam logic [7:0] FPP_CTRL1_WMASK = 8'h4F;
   localparam logic [7:0] FPP_CTRL2_WMASK = 8'h03;
   typedef enum logic [2:0] {
      FPP_IDLE, FPP_PROG, FPP_ERASE, FPP_PVER, FPP_EVER
   } fpp_mode_t;
endpackage : fpp_pkg

// file: rtl/fpp_flash_protect.sv
// Summary of operation
// [RQ1] Gate bit zero protects every block
// [RQ2] Software protection blocks program/erase mode entry
// [RQ3] Per-block select; all-zero refuses everything (the code still enters the verify modes with no block selected)
// [RQ4] Any reset or standby clears registers
// [RQ5] Malfunction sets error flag, enters protection
// [RQ6] Error keeps registers, aborts operation now
// [RQ7] Error protection forbids program/erase re-entry
// [RQ8] Verify modes still allowed under error
// [RQ9] Flash read during operation sets error
// [RQ10] Non-reset exception during operation sets error
// [RQ11] Sleep during operation sets error
// [RQ12] Bus release during operation sets error
// [RQ13] Only power-on reset clears error
// [RQ14] Error with P/E held masks interrupts
// [RQ15] Flash reads during operation are undefined
// [RQ16] Software masks all interrupts during operation
// [RQ17] Gate bit cleared from RAM code
// [RQ18] Four modes chosen by setup and mode bits
// [RQ19] Error flag read-only status bit
`timescale 1ns/100ps
`default_nettype none
module fpp_flash_protect
   import fpp_pkg::*;
#(
   parameter int NBLK = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic porRst,
   input wire logic standbyEntry,
   input wire logic flashRead,
   input wire logic exceptionStart,
   input wire logic sleepExec,
   input wire logic busRelease,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic programPulse,
   output logic erasePulse,
   output logic programVerify,
   output logic eraseVerify,
   output logic [NBLK-1:0] blockEnable,
   output logic readDataUndefined,
   output logic interruptInhibit,
   output logic flashErrorFlag
);
   logic [7:0] ctrl1_q;
   logic [7:0] ctrl2_q;
   logic [NBLK-1:0] ebs_q;
   logic err_q;
   fpp_mode_t mode_q;
   fpp_mode_t mode_d;
   logic wrEn;
   logic rdEn;
   logic clearRegs;
   logic opActive;
   logic errEvent;
   logic swAllow;

   function automatic logic addrHit(input logic [7:0] a, input logic [7:0] r);
      return a == r;
   endfunction : addrHit

   assign wrEn = psel && penable && pwrite;
   assign rdEn = psel && !pwrite;
   assign pready = 1'b1;
   // Reset and standby both count as hardware protection
   assign clearRegs = rst || porRst || standbyEntry; // [RQ4]
   assign opActive = (mode_q == FPP_PROG) || (mode_q == FPP_ERASE);
   assign errEvent = opActive && (flashRead || exceptionStart // [RQ9] [RQ10]
                                  || sleepExec || busRelease); // [RQ11] [RQ12]
   // Gate bit and a non-empty block select must both be present
   assign swAllow = ctrl1_q[FPP_C1_WEG] && (|ebs_q); // [RQ1] [RQ3]

   always_ff @(posedge clk) begin
      if (clearRegs) begin
         ctrl1_q <= FPP_CTRL1_RST; // [RQ4]
      end else if (wrEn && addrHit(paddr, FPP_CTRL1_ADDR)) begin
         ctrl1_q <= pwdata[7:0] & FPP_CTRL1_WMASK;
      end
   end

   always_ff @(posedge clk) begin
      if (clearRegs) begin
         ctrl2_q <= FPP_CTRL2_RST; // [RQ4]
      end else if (wrEn && addrHit(paddr, FPP_CTRL2_ADDR)) begin
         ctrl2_q <= pwdata[7:0] & FPP_CTRL2_WMASK; // [RQ19]
      end
   end

   always_ff @(posedge clk) begin
      if (clearRegs) begin
         ebs_q <= FPP_EBS_RST[NBLK-1:0]; // [RQ4]
      end else if (wrEn && addrHit(paddr, FPP_EBS_ADDR)) begin
         ebs_q <= pwdata[NBLK-1:0]; // [RQ3]
      end
   end

   // Only power-on reset releases the error state; other resets do not
   always_ff @(posedge clk) begin
      if (porRst) begin
         err_q <= 1'b0; // [RQ13]
      end else if (errEvent) begin
         err_q <= 1'b1; // [RQ5]
      end
   end

   always_comb begin
      mode_d = FPP_IDLE;
      if (ctrl1_q[FPP_C1_WEG] && ctrl1_q[FPP_C1_PROG] && ctrl2_q[FPP_C2_PSU]
          && swAllow && !err_q && !errEvent) begin
         mode_d = FPP_PROG; // [RQ2] [RQ6] [RQ7] [RQ18]
      end else if (ctrl1_q[FPP_C1_WEG] && ctrl1_q[FPP_C1_ERASE]
                   && ctrl2_q[FPP_C2_ESU] && swAllow && !err_q && !errEvent) begin
         mode_d = FPP_ERASE; // [RQ2] [RQ6] [RQ7] [RQ18]
      end else if (ctrl1_q[FPP_C1_WEG] && ctrl1_q[FPP_C1_PV]) begin
         mode_d = FPP_PVER; // [RQ8] [RQ18]
      end else if (ctrl1_q[FPP_C1_WEG] && ctrl1_q[FPP_C1_EV]) begin
         mode_d = FPP_EVER; // [RQ8] [RQ18]
      end
   end

   always_ff @(posedge clk) begin
      if (clearRegs) begin
         mode_q <= FPP_IDLE;
      end else begin
         mode_q <= mode_d;
      end
   end

   always_ff @(posedge clk) begin
      if (clearRegs) begin
         prdata <= 32'h0000_0000;
      end else if (rdEn && !penable) begin
         if (addrHit(paddr, FPP_CTRL1_ADDR)) begin
            prdata <= {24'h00_0000, ctrl1_q};
         end else if (addrHit(paddr, FPP_CTRL2_ADDR)) begin
            prdata <= {24'h00_0000, err_q, ctrl2_q[6:0]}; // [RQ19]
         end else if (addrHit(paddr, FPP_EBS_ADDR)) begin
            prdata <= {{(32-NBLK){1'b0}}, ebs_q};
         end else if (addrHit(paddr, FPP_STATUS_ADDR)) begin
            prdata <= {26'h000_0000, interruptInhibit, err_q,
                       mode_q == FPP_EVER, mode_q == FPP_PVER,
                       mode_q == FPP_ERASE, mode_q == FPP_PROG};
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   assign pslverr = psel && penable && !(addrHit(paddr, FPP_CTRL1_ADDR)
      || addrHit(paddr, FPP_CTRL2_ADDR) || addrHit(paddr, FPP_EBS_ADDR)
      || addrHit(paddr, FPP_STATUS_ADDR));

   // Operation outputs drop in the same cycle as the error event
   assign programPulse = (mode_q == FPP_PROG) && !errEvent; // [RQ6]
   assign erasePulse = (mode_q == FPP_ERASE) && !errEvent; // [RQ6]
   assign programVerify = (mode_q == FPP_PVER);
   assign eraseVerify = (mode_q == FPP_EVER);
   assign blockEnable = ebs_q & {NBLK{ctrl1_q[FPP_C1_WEG]}}; // [RQ1] [RQ3]
   // Array data cannot be trusted while P or E is written
   assign readDataUndefined = ctrl1_q[FPP_C1_PROG] || ctrl1_q[FPP_C1_ERASE]; // [RQ15]
   // Software is still expected to mask sources itself
   assign interruptInhibit = opActive || (err_q && readDataUndefined); // [RQ14] [RQ16]
   assign flashErrorFlag = err_q; // [RQ5]

   enter_err_a: assert property (@(posedge clk) disable iff (porRst)
      errEvent |=> err_q && !programPulse && !erasePulse) // [RQ5]
      else $error("error event did not enter error protection");
   keep_regs_a: assert property (@(posedge clk) disable iff (clearRegs)
      errEvent && !wrEn |=> $stable(ctrl1_q) && $stable(ebs_q)) // [RQ6]
      else $error("registers changed on error entry");
   no_reentry_a: assert property (@(posedge clk) disable iff (clearRegs)
      err_q |-> !opActive ##1 !opActive) // [RQ7]
      else $error("program or erase entered under error");
   // Block enables follow the gate at once; the mode register lags by one cycle
   gate_off_a: assert property (@(posedge clk) disable iff (clearRegs)
      !ctrl1_q[FPP_C1_WEG] |-> blockEnable == '0 ##1 !opActive) // [RQ1]
      else $error("operation with gate bit clear");
   err_quiet_a: assert property (@(posedge clk) disable iff (clearRegs)
      err_q |-> !programPulse && !erasePulse) // [RQ7]
      else $error("operation output active under error");
   sw_noset_a: assert property (@(posedge clk)
      !err_q && !errEvent && !porRst |=> !err_q) // [RQ19]
      else $error("error flag set without an error event");
   ev_ok_a: assert property (@(posedge clk) disable iff (clearRegs)
      err_q && ctrl1_q[FPP_C1_WEG] && ctrl1_q[FPP_C1_EV] && !ctrl1_q[FPP_C1_PV]
      && !ctrl1_q[FPP_C1_PROG] && !ctrl1_q[FPP_C1_ERASE] |=> eraseVerify) // [RQ8]
      else $error("erase verify refused under error");
   unmapped_a: assert property (@(posedge clk)
      psel && penable && paddr == 8'h10 |-> pslverr)
      else $error("unmapped access not flagged");
   empty_sel_a: assert property (@(posedge clk) disable iff (clearRegs)
      ebs_q == '0 |=> !opActive) // [RQ3]
      else $error("operation with no block selected");
   reset_clear_a: assert property (@(posedge clk)
      clearRegs |=> ctrl1_q == FPP_CTRL1_RST && ebs_q == '0 && mode_q == FPP_IDLE) // [RQ4]
      else $error("reset did not clear registers");
   por_only_a: assert property (@(posedge clk)
      err_q && !porRst |=> err_q) // [RQ13]
      else $error("error flag released without power-on reset");
   verify_ok_a: assert property (@(posedge clk) disable iff (clearRegs)
      err_q && ctrl1_q[FPP_C1_WEG] && ctrl1_q[FPP_C1_PV] && !ctrl1_q[FPP_C1_PROG]
      && !ctrl1_q[FPP_C1_ERASE] |=> programVerify) // [RQ8]
      else $error("verify refused under error");
   irq_hold_a: assert property (@(posedge clk) disable iff (clearRegs)
      err_q && readDataUndefined |-> interruptInhibit) // [RQ14]
      else $error("interrupts not held off in error state");
   cv_prog_c: cover property (@(posedge clk) disable iff (clearRegs) programPulse);
   cv_erase_c: cover property (@(posedge clk) disable iff (clearRegs) erasePulse);
   cv_err_c: cover property (@(posedge clk) disable iff (clearRegs) opActive ##1 err_q);
   cv_errver_c: cover property (@(posedge clk) disable iff (clearRegs) err_q && eraseVerify);
endmodule : fpp_flash_protect
`default_nettype wire

// file: test/fpp_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module fpp_cpu_model (
   input wire logic clk,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] evt
);
   initial begin
      {psel, penable, pwrite, paddr, pwdata, evt} = '0;
   end
   // Control code runs from RAM with interrupts masked, so xfer makes only register cycles; pulse injects the CPU events
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e, output logic to);
      int n;
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 16);
      r = prdata;
      e = pslverr;
      to = (n >= 16);
      psel <= 1'h0;
      penable <= 1'h0;
      pwdata <= ~d;
   endtask : xfer
   // One-cycle CPU event: flash read, exception, sleep, bus release
   task automatic pulse(input int i);
      @(posedge clk);
      evt[i] <= 1'h1;
      @(posedge clk);
      evt <= 4'h0;
   endtask : pulse
endmodule : fpp_cpu_model
`default_nettype wire

// file: test/fpp_flash_protect_tb.sv
`timescale 1ns/100ps
`default_nettype none
module fpp_flash_protect_tb;
   import fpp_pkg::*;
   logic clk, rst, porRst, standbyEntry, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, blockEnable;
   logic [31:0] pwdata, prdata;
   logic [3:0] evt;
   logic programPulse, erasePulse, programVerify, eraseVerify;
   logic readDataUndefined, interruptInhibit, flashErrorFlag;
   int fail_count = 0;
   int cmp_count = 0;
   initial clk = 1'h0;
   always #2.5 clk = ~clk;
   fpp_flash_protect #(.NBLK(8)) u_fpp_flash_protect (.clk(clk), .rst(rst), .porRst(porRst),
      .standbyEntry(standbyEntry), .flashRead(evt[0]), .exceptionStart(evt[1]),
      .sleepExec(evt[2]), .busRelease(evt[3]), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .programPulse(programPulse), .erasePulse(erasePulse),
      .programVerify(programVerify), .eraseVerify(eraseVerify), .blockEnable(blockEnable),
      .readDataUndefined(readDataUndefined), .interruptInhibit(interruptInhibit),
      .flashErrorFlag(flashErrorFlag));
   fpp_cpu_model u_fpp_cpu_model (.clk(clk), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .evt(evt));
   task automatic print_verdict;
      $display("Checks %0d errors %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      cmp_count++;
      if (g !== x) begin
         fail_count++;
         $display("Error t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask : chk
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e);
      logic to;
      u_fpp_cpu_model.xfer(w, a, d, r, e, to);
      if (to) begin
         fail_count++;
         print_verdict();
      end
   endtask : acc
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      acc(1'h1, a, d, r, e);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      acc(1'h0, a, 32'h0, r, e);
      chk(r, x);
   endtask : rdc
   // Mode register lags the control write by one cycle
   task automatic settle;
      repeat (2) @(negedge clk);
   endtask : settle
   task automatic hwrst(input logic por);
      @(posedge clk);
      rst <= ~por;
      porRst <= por;
      @(posedge clk);
      rst <= 1'h0;
      porRst <= 1'h0;
      @(negedge clk);
   endtask : hwrst
   task automatic enter(input logic m);
      wr(FPP_EBS_ADDR, 32'h01);
      wr(FPP_CTRL2_ADDR, m ? 32'h02 : 32'h01);
      wr(FPP_CTRL1_ADDR, m ? 32'h42 : 32'h41);
      settle();
   endtask : enter
   task automatic t_map;
      logic [31:0] r;
      logic e;
      rdc(FPP_CTRL1_ADDR, 32'h0);
      rdc(FPP_CTRL2_ADDR, 32'h0);
      rdc(FPP_EBS_ADDR, 32'h0);
      acc(1'h0, 8'h10, 32'h0, r, e);
      chk(r, 32'h0);
      chk({31'h0, e}, 32'h1);
   endtask : t_map
   task automatic t_soft;
      wr(FPP_EBS_ADDR, 32'hFF);
      wr(FPP_CTRL2_ADDR, 32'h01);
      wr(FPP_CTRL1_ADDR, 32'h01);
      settle();
      chk({blockEnable, programPulse}, 9'h0);
      wr(FPP_EBS_ADDR, 32'h00);
      wr(FPP_CTRL1_ADDR, 32'h41);
      settle();
      chk(programPulse, 1'h0);
      hwrst(1'h1);
   endtask : t_soft
   task automatic t_mode(input logic m);
      enter(m);
      chk({erasePulse, programPulse}, m ? 2'h2 : 2'h1);
      chk({blockEnable, readDataUndefined}, 9'h3);
      hwrst(1'h1);
   endtask : t_mode
   task automatic t_err(input int i);
      enter(i[0]);
      u_fpp_cpu_model.pulse(i);
      @(negedge clk);
      chk({flashErrorFlag, erasePulse, programPulse}, 3'h4);
      rdc(FPP_CTRL1_ADDR, i[0] ? 32'h42 : 32'h41);
      wr(FPP_CTRL1_ADDR, i[0] ? 32'h42 : 32'h41);
      settle();
      chk({interruptInhibit, erasePulse, programPulse}, 3'h4);
      wr(FPP_CTRL1_ADDR, i[0] ? 32'h4A : 32'h45);
      settle();
      chk({eraseVerify, programVerify}, i[0] ? 2'h2 : 2'h1);
      rdc(FPP_STATUS_ADDR, i[0] ? 32'h38 : 32'h34);
      wr(FPP_CTRL2_ADDR, 32'h0);
      rdc(FPP_CTRL2_ADDR, 32'h80);
      hwrst(1'h0);
      chk(flashErrorFlag, 1'h1);
      rdc(FPP_CTRL1_ADDR, 32'h0);
      hwrst(1'h1);
      chk(flashErrorFlag, 1'h0);
   endtask : t_err
   task automatic t_stby;
      enter(1'h0);
      @(posedge clk);
      standbyEntry <= 1'h1;
      @(posedge clk);
      standbyEntry <= 1'h0;
      @(negedge clk);
      chk(programPulse, 1'h0);
      rdc(FPP_EBS_ADDR, 32'h0);
   endtask : t_stby
   initial begin
      rst = 1'h1;
      porRst = 1'h1;
      standbyEntry = 1'h0;
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      porRst <= 1'h0;
      t_map();
      t_soft();
      t_mode(1'h0);
      t_mode(1'h1);
      for (int i = 0; i < 4; i++) t_err(i);
      t_stby();
      print_verdict();
   end
endmodule : fpp_flash_protect_tb
`default_nettype wire
